// >>> core/ccl_pkg.sv
// Constants, register map and types for the converter control logic.
package ccl_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_RESULT_LO = 8'h78;
  localparam logic [7:0] IDX_RESULT_HI = 8'h79;
  localparam logic [7:0] IDX_CTRL = 8'h7A;
  localparam logic [7:0] IDX_TRIG_SRC = 8'h7B;
  localparam logic [7:0] IDX_INPUT_SEL = 8'h7C;
  localparam int ADDR_W = 10;
  localparam int IDX_SHIFT = 2;

  // Control register fields.
  localparam int CTRL_EN = 7;
  localparam int CTRL_START = 6;
  localparam int CTRL_ATE = 5;
  localparam int CTRL_DONE = 4;
  localparam int CTRL_IE = 3;
  localparam int CTRL_PS_HI = 2;
  localparam int CTRL_PS_LO = 0;

  // Input select and trigger source register fields.
  localparam int SEL_ALIGN = 5;
  localparam int SEL_CH_HI = 4;
  localparam int SEL_CH_LO = 0;
  localparam int SEL_REF_HI = 7;
  localparam int SEL_REF_LO = 6;
  localparam int TRIG_HI = 2;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [2:0] TRIG_RESET = 3'h0;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  localparam logic [2:0] TRIG_FREE_RUN = 3'h0;

  // Converter clock cycles per conversion.
  localparam logic [4:0] CONV_FIRST_CYC = 5'h19;
  localparam logic [4:0] CONV_NORM_CYC = 5'h0D;

  // Channel and gain selection codes.
  localparam logic [4:0] CH_SE_LAST = 5'h07;
  localparam logic [4:0] CH_DIFF_GAIN_LAST = 5'h0F;
  localparam logic [4:0] CH_BANDGAP = 5'h1E;
  localparam logic [4:0] CH_GROUND = 5'h1F;
  localparam logic [2:0] NEG_IN0 = 3'h0;
  localparam logic [2:0] NEG_IN1 = 3'h1;
  localparam logic [2:0] NEG_IN2 = 3'h2;

  typedef enum logic [1:0] {
    CCL_GAIN_1X = 2'h0,
    CCL_GAIN_10X = 2'h1,
    CCL_GAIN_200X = 2'h2
  } ccl_gain_e;

  typedef enum logic [1:0] {
    CCL_IDLE = 2'b01,
    CCL_CONV = 2'b10
  } ccl_state_e;

endpackage

// >>> core/ccl_converter_control.sv
// Converter control logic: registers, prescaler, sequencing and result view.
//
// Notes on behaviour
// - Alignment bit picks left or right result view, effective immediately.
// - Channel/gain field changes apply only after the running conversion completes.
// - Codes 0-7 select single inputs; 11110 bandgap, 11111 ground.
// - Codes 01xxx are 10x/200x pairs; 10000-11101 are unity-gain pairs.
// - Enable bit turns converter on/off; clearing it aborts a conversion.
// - Start bit begins one conversion; in free-running only the first.
// - First conversion after enable takes 25 converter clocks, others 13.
// - Start bit reads one while busy; writing zero to it is ignored.
// - With auto-trigger on, a rising edge of the selected trigger starts conversion.
// - Completion flag sets when a conversion finishes; result is updated unless the read lock is held.
// - Completion flag clears on vector acknowledge or by writing one.
// - Interrupt request only while flag, enable and global enable all set.
// - Prescaler divides system clock by 2,2,4,8,16,32,64,128.
// - Result low byte at base, high byte at next offset, both read-only.
// - Reading low byte locks result updates until high byte is read.
// - Differential results stored two's complement, single-ended unsigned.
// - Alignment resets to right; right view has upper bits zero.
// - Trigger source 000 is free-running; switching to it makes no trigger.
// - Left view puts result 9:2 in bits 15:8 and 1:0 in 7:6.
`timescale 1ns/10ps
module ccl_converter_control
  import ccl_pkg::*;
#(
  parameter int DIV_CNT_W = 7,
  parameter int RES_W = 10
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] trigSources,
  input wire logic globalIrqEn,
  input wire logic irqVectorAck,
  output logic doneIrq,
  output logic convTick,
  output logic anaStart,
  output logic [2:0] anaPosInput,
  output logic [2:0] anaNegInput,
  output logic [1:0] anaGain,
  output logic anaDifferential,
  output logic anaBandgap,
  output logic anaGround,
  input wire logic [RES_W-1:0] anaResult
);

  // The divider counter must hold a count of 127 and the result view is built for ten bits.
  // Other values are refused when the design is elaborated.
  if (DIV_CNT_W < 7 || RES_W != 10) begin : gParamCheck
    $error("ccl_converter_control: DIV_CNT_W must be at least 7 and RES_W must be 10.");
  end

  // Reset release through two flip-flops.
  logic rstMeta_q;
  logic rstSync_q;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end
  logic rstN;
  assign rstN = rstSync_q;

  // Bus slave: one wait cycle, then the access completes.
  logic ack_q;
  logic [7:0] accIdx;
  logic accMapped;
  logic wrDone;
  logic rdDone;
  assign accIdx = avs_address[IDX_SHIFT +: 8];
  assign accMapped = (avs_address[IDX_SHIFT-1:0] == '0);
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign wrDone = clkEn & ack_q & avs_write & avs_byteenable[0] & accMapped;
  assign rdDone = clkEn & ack_q & avs_read & accMapped;

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      ack_q <= 1'b0;
    end else if (clkEn) begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  logic wrCtrl;
  logic wrSel;
  logic wrTrig;
  assign wrCtrl = wrDone & (accIdx == IDX_CTRL);
  assign wrSel = wrDone & (accIdx == IDX_INPUT_SEL);
  assign wrTrig = wrDone & (accIdx == IDX_TRIG_SRC);
  logic [7:0] wByte;
  assign wByte = avs_writedata[7:0];

  // Software-held control state.
  logic enable_q;
  logic autoTrig_q;
  logic irqEnable_q;
  logic [2:0] divSel_q;
  logic [7:0] inputSel_q;
  logic [2:0] trigSrc_q;

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      enable_q <= CTRL_RESET[CTRL_EN];
      autoTrig_q <= CTRL_RESET[CTRL_ATE];
      irqEnable_q <= CTRL_RESET[CTRL_IE];
      divSel_q <= CTRL_RESET[CTRL_PS_HI:CTRL_PS_LO];
    end else if (clkEn && wrCtrl) begin
      enable_q <= wByte[CTRL_EN];
      autoTrig_q <= wByte[CTRL_ATE];
      irqEnable_q <= wByte[CTRL_IE];
      divSel_q <= wByte[CTRL_PS_HI:CTRL_PS_LO];
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      inputSel_q <= SEL_RESET;
      trigSrc_q <= TRIG_RESET;
    end else if (clkEn) begin
      if (wrSel) begin
        inputSel_q <= wByte;
      end
      if (wrTrig) begin
        trigSrc_q <= wByte[TRIG_HI:0];
      end
    end
  end

  // Prescaler, running only while enabled and restarting at enable.
  logic [DIV_CNT_W-1:0] divCnt_q;
  logic [DIV_CNT_W-1:0] divLast;
  logic tick;
  always_comb begin
    case (divSel_q)
      3'h0, 3'h1: divLast = DIV_CNT_W'(1);
      default: divLast = DIV_CNT_W'((32'h1 << divSel_q) - 32'h1);
    endcase
  end
  assign tick = enable_q & (divCnt_q == divLast);

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      divCnt_q <= '0;
    end else if (clkEn) begin
      if (!enable_q || tick) begin
        divCnt_q <= '0;
      end else begin
        divCnt_q <= divCnt_q + DIV_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      convTick <= 1'b0;
    end else if (clkEn) begin
      convTick <= tick;
    end
  end

  // Trigger edge detection on the selected source.
  logic trigLevel;
  logic trigPrev_q;
  logic trigEdge;
  assign trigLevel = (trigSrc_q == TRIG_FREE_RUN) ? 1'b0 : trigSources[trigSrc_q];
  assign trigEdge = autoTrig_q & trigLevel & ~trigPrev_q;
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      trigPrev_q <= 1'b0;
    end else if (clkEn) begin
      trigPrev_q <= trigLevel;
    end
  end

  // Conversion sequencer.
  ccl_state_e state_q;
  logic [4:0] cycCnt_q;
  logic [4:0] cycLen_q;
  logic firstPending_q;
  logic swStart;
  logic startReq;
  logic convEnd;
  logic freeRun;
  logic enNext;
  assign enNext = wrCtrl ? wByte[CTRL_EN] : enable_q;
  assign swStart = wrCtrl & wByte[CTRL_START];
  assign freeRun = autoTrig_q & (trigSrc_q == TRIG_FREE_RUN);
  assign convEnd = (state_q == CCL_CONV) & tick & (cycCnt_q == cycLen_q - 5'h01);
  assign startReq = enNext & (swStart | trigEdge | (convEnd & freeRun));

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      state_q <= CCL_IDLE;
      cycCnt_q <= '0;
      cycLen_q <= CONV_NORM_CYC;
    end else if (clkEn) begin
      case (state_q)
        CCL_IDLE: begin
          if (startReq) begin
            state_q <= CCL_CONV;
            cycCnt_q <= '0;
            cycLen_q <= firstPending_q | (wrCtrl & ~enable_q) ? CONV_FIRST_CYC : CONV_NORM_CYC;
          end
        end
        CCL_CONV: begin
          if (!enNext) begin
            state_q <= CCL_IDLE;
          end else if (convEnd) begin
            cycCnt_q <= '0;
            cycLen_q <= CONV_NORM_CYC;
            if (!startReq) begin
              state_q <= CCL_IDLE;
            end
          end else if (tick) begin
            cycCnt_q <= cycCnt_q + 5'h01;
          end
        end
        default: state_q <= CCL_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      firstPending_q <= 1'b0;
    end else if (clkEn) begin
      if (state_q == CCL_IDLE && startReq) begin
        firstPending_q <= 1'b0;
      end else if (wrCtrl && wByte[CTRL_EN] && !enable_q) begin
        firstPending_q <= 1'b1;
      end
    end
  end

  // Selection is latched while no conversion runs and in the last cycle of each conversion.
  logic [4:0] activeSel_q;
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      activeSel_q <= '0;
    end else if (clkEn && (state_q == CCL_IDLE || convEnd)) begin
      activeSel_q <= inputSel_q[SEL_CH_HI:SEL_CH_LO];
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      anaStart <= 1'b0;
    end else if (clkEn) begin
      anaStart <= startReq & (state_q == CCL_IDLE || convEnd);
    end
  end

  // Input decode of the applied selection.
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      anaPosInput <= '0;
      anaNegInput <= '0;
      anaGain <= CCL_GAIN_1X;
      anaDifferential <= 1'b0;
      anaBandgap <= 1'b0;
      anaGround <= 1'b0;
    end else if (clkEn) begin
      anaPosInput <= activeSel_q[2:0];
      anaBandgap <= (activeSel_q == CH_BANDGAP);
      anaGround <= (activeSel_q == CH_GROUND);
      anaDifferential <= (activeSel_q > CH_SE_LAST) && (activeSel_q < CH_BANDGAP);
      if (activeSel_q <= CH_SE_LAST) begin
        anaNegInput <= NEG_IN0;
        anaGain <= CCL_GAIN_1X;
      end else if (activeSel_q <= CH_DIFF_GAIN_LAST) begin
        anaNegInput <= activeSel_q[2] ? NEG_IN2 : NEG_IN0;
        anaPosInput <= (activeSel_q[2] ? NEG_IN2 : NEG_IN0) + {2'h0, activeSel_q[0]};
        anaGain <= activeSel_q[1] ? CCL_GAIN_200X : CCL_GAIN_10X;
      end else begin
        anaNegInput <= activeSel_q[3] ? NEG_IN2 : NEG_IN1;
        anaGain <= CCL_GAIN_1X;
      end
    end
  end

  // Result capture, read lock and completion flag.
  logic [RES_W-1:0] result_q;
  logic readLock_q;
  logic doneFlag_q;
  logic rdLo;
  logic rdHi;
  assign rdLo = rdDone & (accIdx == IDX_RESULT_LO);
  assign rdHi = rdDone & (accIdx == IDX_RESULT_HI);

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      result_q <= RESULT_RESET;
    end else if (clkEn && convEnd && !readLock_q) begin
      result_q <= anaResult;
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      readLock_q <= 1'b0;
    end else if (clkEn) begin
      if (rdHi) begin
        readLock_q <= 1'b0;
      end else if (rdLo) begin
        readLock_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      doneFlag_q <= 1'b0;
    end else if (clkEn) begin
      if (convEnd) begin
        doneFlag_q <= 1'b1;
      end else if (irqVectorAck || (wrCtrl && wByte[CTRL_DONE])) begin
        doneFlag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      doneIrq <= 1'b0;
    end else if (clkEn) begin
      doneIrq <= doneFlag_q & irqEnable_q & globalIrqEn;
    end
  end

  // Read data view.
  logic [15:0] resultView;
  logic [7:0] rdByte;
  assign resultView = inputSel_q[SEL_ALIGN] ? {result_q, 6'h00} : {6'h00, result_q};
  always_comb begin
    rdByte = 8'h00;
    if (accMapped) begin
      case (accIdx)
        IDX_RESULT_LO: rdByte = resultView[7:0];
        IDX_RESULT_HI: rdByte = resultView[15:8];
        IDX_CTRL: rdByte = {enable_q, state_q == CCL_CONV, autoTrig_q, doneFlag_q, irqEnable_q, divSel_q};
        IDX_TRIG_SRC: rdByte = {5'h00, trigSrc_q};
        IDX_INPUT_SEL: rdByte = inputSel_q;
        default: rdByte = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      avs_readdata <= '0;
    end else if (clkEn && avs_read && !ack_q) begin
      avs_readdata <= {24'h000000, rdByte};
    end
  end

endmodule

// >>> testbench/ccl_ana_model.sv
// Analog core model that returns a code built from the applied selection.
`timescale 1ns/10ps
module ccl_ana_model (
  input wire logic core_clk,
  input wire logic anaStart,
  input wire logic [2:0] anaPosInput,
  input wire logic [2:0] anaNegInput,
  input wire logic [1:0] anaGain,
  input wire logic anaDifferential,
  input wire logic anaBandgap,
  input wire logic anaGround,
  output logic [9:0] anaResult
);
  logic d;
  assign d = anaDifferential;
  initial anaResult = 10'h3FF;
  // The code is latched when a conversion starts, so later selection changes cannot leak into it.
  always @(posedge core_clk) begin
    if (anaStart) begin
      anaResult <= {(anaBandgap | anaGround) ? 3'h0 : anaPosInput, d ? anaNegInput : 3'h0,
                    d ? anaGain : 2'h0, d, anaBandgap};
    end
  end
endmodule

// >>> testbench/ccl_converter_control_properties.sv
// Port-level assertions for the converter control logic.
`timescale 1ns/10ps
module ccl_converter_control_properties
  import ccl_pkg::*;
#(
  parameter int DIV_CNT_W = 7,
  parameter int RES_W = 10
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic globalIrqEn,
  input wire logic doneIrq,
  input wire logic convTick,
  input wire logic anaStart,
  input wire logic [2:0] anaPosInput,
  input wire logic [1:0] anaGain,
  input wire logic anaDifferential,
  input wire logic anaBandgap,
  input wire logic anaGround
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  chk_wait_one:
    assert property ((avs_read || avs_write) && avs_waitrequest && clkEn |=> !avs_waitrequest)
    else $error("waitrequest held too long");
  chk_wait_idle:
    assert property (!(avs_read || avs_write) |-> !avs_waitrequest) else $error("waitrequest without request");
  chk_rdata_upper:
    assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  chk_irq_gate:
    assert property (!globalIrqEn |=> !doneIrq) else $error("irq without global enable");
  chk_tick_gap:
    assert property (convTick && clkEn |=> !convTick) else $error("converter tick too fast");
  chk_start_gap:
    assert property (anaStart |=> !anaStart [*8]) else $error("conversion too short");
  chk_sel_hold:
    assert property (anaStart |-> ##2 $stable({anaPosInput, anaGain, anaDifferential}) [*8])
    else $error("selection changed in conversion");
  chk_gnd_only:
    assert property (anaGround |-> !anaDifferential && !anaBandgap) else $error("ground decode clash");
  chk_gain_diff:
    assert property (anaGain != 2'h0 |-> anaDifferential) else $error("gain on single input");
endmodule
bind ccl_converter_control ccl_converter_control_properties #(.DIV_CNT_W(DIV_CNT_W), .RES_W(RES_W)) i_ccl_props (
  .core_clk, .resetn, .clkEn, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .globalIrqEn,
  .doneIrq, .convTick, .anaStart, .anaPosInput, .anaGain, .anaDifferential, .anaBandgap, .anaGround);

// >>> testbench/tb_top.sv
// Register-level test sequence for the converter control logic.
`timescale 1ns/10ps
module tb_top;
  import ccl_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic rdEn = 1'b0;
  logic wrEn = 1'b0;
  logic [31:0] wData = 32'h00000000;
  logic [3:0] byteEn = 4'hF;
  logic [7:0] trig = 8'h00;
  logic gIe = 1'b0;
  logic vecAck = 1'b0;
  logic ce = 1'b1;
  logic [31:0] rData;
  logic waitReq, irq, tick, aStart, diff, bg, gnd;
  logic [2:0] pos, neg;
  logic [1:0] gain;
  logic [9:0] aRes;
  int errorCnt = 0;
  int checked = 0;
  int cyc = 0;
  int st[$];
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  always @(posedge core_clk) if (aStart === 1'b1) st.push_back(cyc);
  ccl_converter_control i_ccl_converter_control (.core_clk(core_clk), .resetn(resetn), .clkEn(ce),
    .avs_address(addr), .avs_read(rdEn), .avs_write(wrEn), .avs_writedata(wData), .avs_byteenable(byteEn),
    .avs_readdata(rData), .avs_waitrequest(waitReq), .trigSources(trig), .globalIrqEn(gIe),
    .irqVectorAck(vecAck), .doneIrq(irq), .convTick(tick), .anaStart(aStart), .anaPosInput(pos),
    .anaNegInput(neg), .anaGain(gain), .anaDifferential(diff), .anaBandgap(bg), .anaGround(gnd),
    .anaResult(aRes));
  ccl_ana_model i_ccl_ana_model (.core_clk(core_clk), .anaStart(aStart), .anaPosInput(pos),
    .anaNegInput(neg), .anaGain(gain), .anaDifferential(diff), .anaBandgap(bg), .anaGround(gnd),
    .anaResult(aRes));
  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", checked, errorCnt);
    if (errorCnt == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errorCnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
    int n;
    addr <= ADDR_W'(idx) << IDX_SHIFT;
    wrEn <= w;
    rdEn <= ~w;
    wData <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (waitReq !== 1'b0 && n < 20);
    q = rData[7:0];
    wrEn <= 1'b0;
    rdEn <= 1'b0;
    if (n >= 20) begin
      errorCnt++;
      give_verdict();
    end
    @(posedge core_clk);
  endtask
  task automatic conv_wait(output logic [7:0] q);
    int n;
    n = 0;
    do begin
      acc(1'b0, IDX_CTRL, 8'h00, q);
      n++;
    end while (q[CTRL_START] !== 1'b0 && n < 2000);
    if (n >= 2000) begin
      errorCnt++;
      give_verdict();
    end
  endtask
  task automatic starts(input int k);
    int n;
    n = 0;
    while (st.size() < k && n < 9000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 9000) begin
      errorCnt++;
      give_verdict();
    end
  endtask
  task automatic res(input logic [9:0] v, input logic left);
    logic [7:0] q;
    acc(1'b0, IDX_RESULT_LO, 8'h00, q);
    chk("result low", left ? {v[1:0], 6'h00} : v[7:0], q);
    acc(1'b0, IDX_RESULT_HI, 8'h00, q);
    chk("result high", left ? v[9:2] : {6'h00, v[9:8]}, q);
  endtask
  // Expected code of the analog model for each channel and gain selection.
  function automatic logic [9:0] expc(input logic [4:0] c);
    if (c <= CH_SE_LAST) return {c[2:0], 7'h00};
    if (c <= CH_DIFF_GAIN_LAST) return {1'b0, c[2], c[0], 1'b0, c[2], 1'b0, c[1] ? 2'h2 : 2'h1, 2'h2};
    if (c == CH_BANDGAP) return 10'h001;
    if (c == CH_GROUND) return 10'h000;
    return {c[2:0], c[3] ? NEG_IN2 : NEG_IN1, 4'h2};
  endfunction
  logic [7:0] q;
  logic [7:0] regs [6] = '{IDX_RESULT_LO, IDX_RESULT_HI, IDX_CTRL, IDX_TRIG_SRC, IDX_INPUT_SEL, 8'h7D};
  int n0, dv;
  initial begin
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < 6; i++) if (i < 2 || i == 5) acc(1'b1, regs[i], 8'hFF, q);
    byteEn <= 4'h0;
    acc(1'b1, IDX_INPUT_SEL, 8'h3F, q);
    byteEn <= 4'hF;
    for (int i = 0; i < 6; i++) begin
      acc(1'b0, regs[i], 8'h00, q);
      chk("reset value", 8'h00, q);
    end
    acc(1'b1, IDX_CTRL, 8'h80, q);
    for (int c = 0; c < 32; c++) begin
      acc(1'b1, IDX_INPUT_SEL, 8'(c), q);
      acc(1'b1, IDX_CTRL, 8'hD0, q);
      conv_wait(q);
      chk("done flag", 8'h90, q);
      res(expc(5'(c)), 1'b0);
      acc(1'b1, IDX_INPUT_SEL, 8'(c) | 8'h20, q);
      res(expc(5'(c)), 1'b1);
    end
    acc(1'b1, IDX_INPUT_SEL, 8'h13, q);
    acc(1'b1, IDX_CTRL, 8'hD0, q);
    acc(1'b1, IDX_INPUT_SEL, 8'h1E, q);
    acc(1'b1, IDX_CTRL, 8'h80, q);
    acc(1'b0, IDX_CTRL, 8'h00, q);
    chk("busy", 8'hC0, q);
    conv_wait(q);
    res(expc(5'h13), 1'b0);
    acc(1'b0, IDX_RESULT_LO, 8'h00, q);
    acc(1'b1, IDX_CTRL, 8'hD0, q);
    conv_wait(q);
    acc(1'b0, IDX_RESULT_HI, 8'h00, q);
    chk("locked high", 8'h01, q);
    res(expc(5'h13), 1'b0);
    acc(1'b1, IDX_CTRL, 8'hD0, q);
    conv_wait(q);
    res(10'h001, 1'b0);
    acc(1'b1, IDX_CTRL, 8'hD0, q);
    acc(1'b1, IDX_CTRL, 8'h00, q);
    repeat (10) acc(1'b0, IDX_CTRL, 8'h00, q);
    chk("aborted", 8'h00, q);
    for (int p = 0; p < 8; p++) begin
      acc(1'b1, IDX_CTRL, 8'h00, q);
      repeat (10) @(posedge core_clk);
      n0 = st.size();
      acc(1'b1, IDX_CTRL, 8'hF0 | 8'(p), q);
      starts(n0 + 3);
      dv = (p < 2) ? 2 : (1 << p);
      chk("first length", 25 * dv, st[n0 + 1] - st[n0]);
      chk("later length", 13 * dv, st[n0 + 2] - st[n0 + 1]);
    end
    acc(1'b1, IDX_CTRL, 8'h10, q);
    acc(1'b1, IDX_TRIG_SRC, 8'h03, q);
    acc(1'b1, IDX_CTRL, 8'hB0, q);
    n0 = st.size();
    trig <= 8'h08;
    starts(n0 + 1);
    trig <= 8'hF7;
    conv_wait(q);
    acc(1'b1, IDX_TRIG_SRC, 8'h00, q);
    repeat (10) acc(1'b0, IDX_CTRL, 8'h00, q);
    chk("start count", n0 + 1, st.size());
    trig <= 8'h00;
    acc(1'b1, IDX_CTRL, 8'h88, q);
    repeat (2) @(posedge core_clk);
    chk("irq masked", 1'b0, irq);
    gIe <= 1'b1;
    acc(1'b0, IDX_CTRL, 8'h00, q);
    chk("irq raised", 1'b1, irq);
    vecAck <= 1'b1;
    @(posedge core_clk);
    vecAck <= 1'b0;
    acc(1'b0, IDX_CTRL, 8'h00, q);
    chk("acked flag", 8'h88, q);
    chk("irq dropped", 1'b0, irq);
    acc(1'b1, IDX_CTRL, 8'hC8, q);
    conv_wait(q);
    chk("irq again", 1'b1, irq);
    ce <= 1'b0;
    vecAck <= 1'b1;
    repeat (4) @(posedge core_clk);
    ce <= 1'b1;
    vecAck <= 1'b0;
    acc(1'b0, IDX_CTRL, 8'h00, q);
    chk("frozen flag", 8'h98, q);
    chk("frozen irq", 1'b1, irq);
    acc(1'b1, IDX_CTRL, 8'h98, q);
    acc(1'b0, IDX_CTRL, 8'h00, q);
    chk("cleared flag", 8'h88, q);
    give_verdict();
  end
endmodule
